// ---- hw/aclc_pkg.sv ----
// Purpose: Shared constants and types of the axis counter, latch and compare block.
// Assumes: APB register map with one aligned 32-bit word per register index.
// Notes:   Printed offsets are register indices; byte address is four times the index.
package aclc_pkg;
  localparam logic [7:0] IDX_LATCH_CFG   = 8'h9F;
  localparam logic [7:0] IDX_POS_ONE     = 8'hA3;
  localparam logic [7:0] IDX_POS_TWO     = 8'hA4;
  localparam logic [7:0] IDX_CMP_ONE     = 8'hA7;
  localparam logic [7:0] IDX_CMP_TWO     = 8'hA8;
  localparam logic [7:0] IDX_SLIM_A      = 8'hA9;
  localparam logic [7:0] IDX_SLIM_B      = 8'hAA;
  localparam logic [7:0] IDX_IRQ_EN      = 8'hAC;
  localparam logic [7:0] IDX_CAP_ONE     = 8'hED;
  localparam logic [7:0] IDX_CAP_TWO     = 8'hEE;
  localparam logic [7:0] IDX_CAP_THREE   = 8'hEF;
  localparam logic [7:0] IDX_CAP_FOUR    = 8'hF0;
  localparam logic [7:0] IDX_ERR_CAUSE   = 8'hB2;
  localparam logic [7:0] IDX_EVT_CAUSE   = 8'hB3;
  localparam logic [7:0] IDX_CTRL        = 8'hC0;
  localparam logic [7:0] IDX_STATUS      = 8'hC1;

  localparam int CAP3_LSB = 0;
  localparam int CAP4_LSB = 8;
  localparam int SLIM_ACTION_LSB = 0;
  localparam int SLIM_CNT_SEL_BIT = 2;
  localparam int CTRL_ARM3_BIT = 0;
  localparam int CTRL_ARM4_BIT = 1;
  localparam int CTRL_LATCH_BIT = 2;
  localparam int CTRL_SLIM_LSB = 3;
  localparam int EVT_LAT_BIT = 8;
  localparam int EVT_SLP_BIT = 14;
  localparam int EVT_SLN_BIT = 15;
  localparam int EVT_L3_BIT = 18;
  localparam int EVT_L4_BIT = 19;
  localparam int ERR_SLP_BIT = 9;
  localparam int ERR_SLN_BIT = 10;
  localparam int IRQ_L3_BIT = 16;
  localparam int IRQ_L4_BIT = 17;
  localparam int IRQ_LAT_BIT = 8;

  localparam logic [31:0] IRQ_EN_MASK  = 32'h0003_FFFF;
  localparam logic [31:0] ERR_MASK     = 32'h0000_07FF;
  localparam logic [31:0] EVT_MASK     = 32'h000F_FFFF;
  localparam logic [31:0] CFG_MASK     = 32'h0000_FFFF;
  localparam logic [31:0] CTRL_MASK    = 32'h0000_0038;
  localparam logic [31:0] ZERO_WORD    = 32'h0000_0000;

  localparam int CLK_MHZ = 200;
  localparam int FILT0_NS = 100;
  localparam int FILT1_NS = 3200;
  localparam int FILT2_NS = 25000;
  localparam int FILT3_NS = 200000;
  localparam int FILT0_CYC = (FILT0_NS * CLK_MHZ + 999) / 1000;
  localparam int FILT1_CYC = (FILT1_NS * CLK_MHZ + 999) / 1000;
  localparam int FILT2_CYC = (FILT2_NS * CLK_MHZ + 999) / 1000;
  localparam int FILT3_CYC = (FILT3_NS * CLK_MHZ + 999) / 1000;

  typedef enum logic [2:0] {
    ACLC_SRC_OFF    = 3'h0,
    ACLC_SRC_LATCH  = 3'h1,
    ACLC_SRC_ORIGIN = 3'h2,
    ACLC_SRC_INDEX  = 3'h3,
    ACLC_SRC_GP4    = 3'h4,
    ACLC_SRC_GP5    = 3'h5,
    ACLC_SRC_GP6    = 3'h6,
    ACLC_SRC_GP7    = 3'h7
  } aclc_src_e;

  typedef struct packed {
    logic [1:0] filter_width;
    logic       repeat_mode;
    logic       counter_select;
    logic       edge_select;
    aclc_src_e  trigger_source;
  } aclc_chan_cfg_s;

  typedef enum logic [1:0] {
    ACLC_SL_IGNORE = 2'h0,
    ACLC_SL_EVENT  = 2'h1,
    ACLC_SL_STOP   = 2'h2,
    ACLC_SL_DECEL  = 2'h3
  } aclc_slim_e;
endpackage

// ---- hw/aclc_top.sv ----
// Purpose: Position counters, compare values and four capture registers behind APB.
// Assumes: Pins are asynchronous and pass a three-stage synchroniser.
// Notes:   Counter increments come from the pulse and encoder logic on the same clock.
//
// The APB slave port was decided locally.
`timescale 1ns/1ps

module aclc_top (
  input  wire logic        CLK_I,
  input  wire logic        RST_N_I,
  input  wire logic [31:0] PADDR_I,
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [31:0] PWDATA_I,
  output logic [31:0]      PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  input  wire logic        CNT1_INC_I,
  input  wire logic        CNT1_DEC_I,
  input  wire logic        CNT2_INC_I,
  input  wire logic        CNT2_DEC_I,
  input  wire logic        LATCH_INPUT_PIN_I,
  input  wire logic        ORIGIN_INPUT_PIN_I,
  input  wire logic        ENCODER_INDEX_PIN_I,
  input  wire logic [3:0]  GENERAL_PIN_I,
  output logic             SLIM_STOP_O,
  output logic             SLIM_DECEL_O,
  output logic             IRQ_O
);
  localparam int NPIN = 7;

  logic [31:0] cfg_r, pos1_r, pos2_r, irq_en_r, err_r, evt_r, ctrl_r;
  logic [31:0] cmp_r [4];
  logic [31:0] cap_r [4];
  logic [NPIN-1:0] s1_r, s2_r, s3_r, pin_r;
  logic [1:0] armed_r;
  logic [1:0] cap_evt;
  logic [1:0] lvl_r;
  logic [17:0] fcnt_r [2];
  logic [1:0] flt_r;
  logic [1:0] flt_prev_r;
  logic lim_pos, lim_neg, latch_cmd;
  logic wr_acc, rd_acc;
  logic [7:0] idx;
  aclc_pkg::aclc_chan_cfg_s ch_cfg [2];

  assign idx    = PADDR_I[9:2];
  assign wr_acc = PSEL_I & PENABLE_I & PWRITE_I & PREADY_O;
  assign rd_acc = PSEL_I & PENABLE_I & ~PWRITE_I & PREADY_O;
  assign ch_cfg[0] = cfg_r[aclc_pkg::CAP3_LSB +: 8];
  assign ch_cfg[1] = cfg_r[aclc_pkg::CAP4_LSB +: 8];
  assign latch_cmd = wr_acc & (idx == aclc_pkg::IDX_CTRL) & PWDATA_I[aclc_pkg::CTRL_LATCH_BIT];

  function automatic logic mapped(input logic [7:0] a);
    unique case (a)
      aclc_pkg::IDX_LATCH_CFG, aclc_pkg::IDX_POS_ONE, aclc_pkg::IDX_POS_TWO,
      aclc_pkg::IDX_CMP_ONE, aclc_pkg::IDX_CMP_TWO, aclc_pkg::IDX_SLIM_A,
      aclc_pkg::IDX_SLIM_B, aclc_pkg::IDX_IRQ_EN, aclc_pkg::IDX_CAP_ONE,
      aclc_pkg::IDX_CAP_TWO, aclc_pkg::IDX_CAP_THREE, aclc_pkg::IDX_CAP_FOUR,
      aclc_pkg::IDX_ERR_CAUSE, aclc_pkg::IDX_EVT_CAUSE, aclc_pkg::IDX_CTRL,
      aclc_pkg::IDX_STATUS: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  endfunction

  function automatic logic [17:0] filt_cycles(input logic [1:0] code);
    unique case (code)
      2'h0: filt_cycles = 18'(aclc_pkg::FILT0_CYC);
      2'h1: filt_cycles = 18'(aclc_pkg::FILT1_CYC);
      2'h2: filt_cycles = 18'(aclc_pkg::FILT2_CYC);
      2'h3: filt_cycles = 18'(aclc_pkg::FILT3_CYC);
    endcase
  endfunction

  // Pins pass three flops; a level counts once the last two agree.
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      s1_r  <= '0;
      s2_r  <= '0;
      s3_r  <= '0;
      pin_r <= '0;
    end else begin
      s1_r <= {GENERAL_PIN_I, ENCODER_INDEX_PIN_I, ORIGIN_INPUT_PIN_I, LATCH_INPUT_PIN_I};
      s2_r <= s1_r;
      s3_r <= s2_r;
      for (int k = 0; k < NPIN; k++) begin
        if (s2_r[k] == s3_r[k]) begin
          pin_r[k] <= s3_r[k];
        end
      end
    end
  end

  // APB answers in the access cycle: zero wait states.
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      PREADY_O  <= 1'b0;
      PSLVERR_O <= 1'b0;
      PRDATA_O  <= aclc_pkg::ZERO_WORD;
    end else begin
      PREADY_O  <= PSEL_I & ~PENABLE_I;
      PSLVERR_O <= PSEL_I & ~PENABLE_I & ~mapped(idx);
      if (PSEL_I & ~PENABLE_I & ~PWRITE_I) begin
        unique case (idx)
          aclc_pkg::IDX_LATCH_CFG: PRDATA_O <= cfg_r;
          aclc_pkg::IDX_POS_ONE:   PRDATA_O <= pos1_r;
          aclc_pkg::IDX_POS_TWO:   PRDATA_O <= pos2_r;
          aclc_pkg::IDX_CMP_ONE:   PRDATA_O <= cmp_r[0];
          aclc_pkg::IDX_CMP_TWO:   PRDATA_O <= cmp_r[1];
          aclc_pkg::IDX_SLIM_A:    PRDATA_O <= cmp_r[2];
          aclc_pkg::IDX_SLIM_B:    PRDATA_O <= cmp_r[3];
          aclc_pkg::IDX_IRQ_EN:    PRDATA_O <= irq_en_r;
          aclc_pkg::IDX_CAP_ONE:   PRDATA_O <= cap_r[0];
          aclc_pkg::IDX_CAP_TWO:   PRDATA_O <= cap_r[1];
          aclc_pkg::IDX_CAP_THREE: PRDATA_O <= cap_r[2];
          aclc_pkg::IDX_CAP_FOUR:  PRDATA_O <= cap_r[3];
          aclc_pkg::IDX_ERR_CAUSE: PRDATA_O <= err_r;
          aclc_pkg::IDX_EVT_CAUSE: PRDATA_O <= evt_r;
          aclc_pkg::IDX_CTRL:      PRDATA_O <= ctrl_r;
          aclc_pkg::IDX_STATUS:    PRDATA_O <= {28'h0000000, lvl_r, armed_r};
          default:                 PRDATA_O <= aclc_pkg::ZERO_WORD;
        endcase
      end
    end
  end

  // Configuration, compare and enable registers.
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      cfg_r    <= aclc_pkg::ZERO_WORD;
      irq_en_r <= aclc_pkg::ZERO_WORD;
      ctrl_r   <= aclc_pkg::ZERO_WORD;
      for (int k = 0; k < 4; k++) begin
        cmp_r[k] <= aclc_pkg::ZERO_WORD;
      end
    end else if (wr_acc) begin
      unique case (idx)
        aclc_pkg::IDX_LATCH_CFG: cfg_r <= PWDATA_I & aclc_pkg::CFG_MASK;
        aclc_pkg::IDX_CMP_ONE:   cmp_r[0] <= PWDATA_I;
        aclc_pkg::IDX_CMP_TWO:   cmp_r[1] <= PWDATA_I;
        aclc_pkg::IDX_SLIM_A:    cmp_r[2] <= PWDATA_I;
        aclc_pkg::IDX_SLIM_B:    cmp_r[3] <= PWDATA_I;
        aclc_pkg::IDX_IRQ_EN:    irq_en_r <= PWDATA_I & aclc_pkg::IRQ_EN_MASK;
        aclc_pkg::IDX_CTRL:      ctrl_r <= PWDATA_I & aclc_pkg::CTRL_MASK;
        default: ;
      endcase
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      pos1_r <= aclc_pkg::ZERO_WORD;
    end else if (wr_acc && idx == aclc_pkg::IDX_POS_ONE) begin
      pos1_r <= PWDATA_I;
    end else if (CNT1_INC_I ^ CNT1_DEC_I) begin
      pos1_r <= CNT1_INC_I ? pos1_r + 32'h0000_0001 : pos1_r - 32'h0000_0001;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      pos2_r <= aclc_pkg::ZERO_WORD;
    end else if (wr_acc && idx == aclc_pkg::IDX_POS_TWO) begin
      pos2_r <= PWDATA_I;
    end else if (CNT2_INC_I ^ CNT2_DEC_I) begin
      pos2_r <= CNT2_INC_I ? pos2_r + 32'h0000_0001 : pos2_r - 32'h0000_0001;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      cap_r[0] <= aclc_pkg::ZERO_WORD;
      cap_r[1] <= aclc_pkg::ZERO_WORD;
    end else if (latch_cmd) begin
      cap_r[0] <= pos1_r;
      cap_r[1] <= pos2_r;
    end
  end

  // Two configurable capture channels.
  for (genvar c = 0; c < 2; c++) begin : g_chan
    logic raw;
    logic arm_cmd;
    always_comb begin
      unique case (ch_cfg[c].trigger_source)
        aclc_pkg::ACLC_SRC_OFF:    raw = 1'b0;
        aclc_pkg::ACLC_SRC_LATCH:  raw = pin_r[0];
        aclc_pkg::ACLC_SRC_ORIGIN: raw = pin_r[1];
        aclc_pkg::ACLC_SRC_INDEX:  raw = pin_r[2];
        default:                   raw = pin_r[3 + 32'(ch_cfg[c].trigger_source) - 4];
      endcase
    end
    assign arm_cmd = wr_acc & (idx == aclc_pkg::IDX_CTRL) & PWDATA_I[c];

    always_ff @(posedge CLK_I) begin
      if (!RST_N_I) begin
        lvl_r[c]  <= 1'b0;
        fcnt_r[c] <= '0;
      end else if (raw == lvl_r[c]) begin
        fcnt_r[c] <= '0;
      end else if (fcnt_r[c] + 18'h00001 >= filt_cycles(ch_cfg[c].filter_width)) begin
        lvl_r[c]  <= raw;
        fcnt_r[c] <= '0;
      end else begin
        fcnt_r[c] <= fcnt_r[c] + 18'h00001;
      end
    end

    assign cap_evt[c] = armed_r[c] & ch_cfg[c].trigger_source != aclc_pkg::ACLC_SRC_OFF &
                        (lvl_r[c] != flt_prev_r[c]) & (lvl_r[c] == ch_cfg[c].edge_select);

    always_ff @(posedge CLK_I) begin
      if (!RST_N_I) begin
        flt_prev_r[c] <= 1'b0;
        armed_r[c]    <= 1'b0;
        cap_r[c+2]    <= aclc_pkg::ZERO_WORD;
      end else begin
        flt_prev_r[c] <= lvl_r[c];
        if (arm_cmd) begin
          armed_r[c] <= 1'b1;
        end else if (cap_evt[c] && !ch_cfg[c].repeat_mode) begin
          armed_r[c] <= 1'b0;
        end
        if (cap_evt[c]) begin
          cap_r[c+2] <= ch_cfg[c].counter_select ? pos2_r : pos1_r;
        end
      end
    end
  end

  always_comb begin
    logic [31:0] cnt;
    cnt = ctrl_r[aclc_pkg::CTRL_SLIM_LSB + aclc_pkg::SLIM_CNT_SEL_BIT] ? pos2_r : pos1_r;
    lim_pos = $signed(cnt) >= $signed(cmp_r[2]);
    lim_neg = $signed(cnt) <= $signed(cmp_r[3]);
  end

  logic [1:0] slact;
  logic lim_pos_d_r, lim_neg_d_r;
  assign slact = ctrl_r[aclc_pkg::CTRL_SLIM_LSB + aclc_pkg::SLIM_ACTION_LSB +: 2];

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      SLIM_STOP_O  <= 1'b0;
      SLIM_DECEL_O <= 1'b0;
      lim_pos_d_r  <= 1'b0;
      lim_neg_d_r  <= 1'b0;
    end else begin
      lim_pos_d_r  <= lim_pos;
      lim_neg_d_r  <= lim_neg;
      SLIM_STOP_O  <= (lim_pos | lim_neg) & (slact == aclc_pkg::ACLC_SL_STOP);
      SLIM_DECEL_O <= (lim_pos | lim_neg) & (slact == aclc_pkg::ACLC_SL_DECEL);
    end
  end

  // cause registers, set wins over write-one clear.
  logic [31:0] eset;
  logic [31:0] rset;

  always_comb begin
    eset = aclc_pkg::ZERO_WORD;
    rset = aclc_pkg::ZERO_WORD;
    eset[aclc_pkg::EVT_L3_BIT]  = cap_evt[0];
    eset[aclc_pkg::EVT_L4_BIT]  = cap_evt[1];
    eset[aclc_pkg::EVT_LAT_BIT] = latch_cmd;
    eset[aclc_pkg::EVT_SLP_BIT] = lim_pos & ~lim_pos_d_r & (slact == aclc_pkg::ACLC_SL_EVENT);
    eset[aclc_pkg::EVT_SLN_BIT] = lim_neg & ~lim_neg_d_r & (slact == aclc_pkg::ACLC_SL_EVENT);
    rset[aclc_pkg::ERR_SLP_BIT] = lim_pos & ~lim_pos_d_r & slact[1];
    rset[aclc_pkg::ERR_SLN_BIT] = lim_neg & ~lim_neg_d_r & slact[1];
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      err_r <= aclc_pkg::ZERO_WORD;
      evt_r <= aclc_pkg::ZERO_WORD;
    end else begin
      if (wr_acc && idx == aclc_pkg::IDX_ERR_CAUSE) begin
        err_r <= ((err_r & ~PWDATA_I) | rset) & aclc_pkg::ERR_MASK;
      end else begin
        err_r <= (err_r | rset) & aclc_pkg::ERR_MASK;
      end
      if (wr_acc && idx == aclc_pkg::IDX_EVT_CAUSE) begin
        evt_r <= ((evt_r & ~PWDATA_I) | eset) & aclc_pkg::EVT_MASK;
      end else begin
        evt_r <= (evt_r | eset) & aclc_pkg::EVT_MASK;
      end
    end
  end

  // Enable bits 16/17 gate event bits 18/19; bits 0..15 map directly.
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      IRQ_O <= 1'b0;
    end else begin
      IRQ_O <= (|(evt_r[15:0] & irq_en_r[15:0])) |
               (evt_r[aclc_pkg::EVT_L3_BIT] & irq_en_r[aclc_pkg::IRQ_L3_BIT]) |
               (evt_r[aclc_pkg::EVT_L4_BIT] & irq_en_r[aclc_pkg::IRQ_L4_BIT]) |
               (|err_r);
    end
  end

  property p_cap3_value;
    @(posedge CLK_I) disable iff (!RST_N_I)
      cap_evt[0] |=> cap_r[2] == ($past(ch_cfg[0].counter_select) ? $past(pos2_r) : $past(pos1_r));
  endproperty
  a_cap3_value: assert property (p_cap3_value) else $error("capture three wrong value");

  function automatic logic arm_any(input int c);
    arm_any = wr_acc & (idx == aclc_pkg::IDX_CTRL) & PWDATA_I[c];
  endfunction

  property p_oneshot;
    @(posedge CLK_I) disable iff (!RST_N_I)
      cap_evt[0] && !ch_cfg[0].repeat_mode && !arm_any(0) |=> !armed_r[0];
  endproperty
  a_oneshot: assert property (p_oneshot) else $error("one-shot channel stayed armed");

  property p_off_no_cap;
    @(posedge CLK_I) disable iff (!RST_N_I)
      ch_cfg[0].trigger_source == aclc_pkg::ACLC_SRC_OFF |=> $stable(cap_r[2]);
  endproperty
  a_off_no_cap: assert property (p_off_no_cap) else $error("disabled channel captured");

  property p_irq_l3;
    @(posedge CLK_I) disable iff (!RST_N_I)
      cap_evt[0] && irq_en_r[aclc_pkg::IRQ_L3_BIT] && !wr_acc |-> ##2 IRQ_O;
  endproperty
  a_irq_l3: assert property (p_irq_l3) else $error("capture three did not interrupt");

  property p_edge;
    @(posedge CLK_I) disable iff (!RST_N_I)
      cap_evt[1] |-> lvl_r[1] == ch_cfg[1].edge_select && $past(lvl_r[1]) != lvl_r[1];
  endproperty
  a_edge: assert property (p_edge) else $error("capture on wrong edge");

  property p_filter;
    @(posedge CLK_I) disable iff (!RST_N_I)
      $changed(lvl_r[0]) |-> $past(fcnt_r[0]) + 18'h00001 >= filt_cycles($past(ch_cfg[0].filter_width));
  endproperty
  a_filter: assert property (p_filter) else $error("filter passed short pulse");

  property p_err_mask;
    @(posedge CLK_I) disable iff (!RST_N_I) err_r[31:11] == '0 && evt_r[31:20] == '0;
  endproperty
  a_err_mask: assert property (p_err_mask) else $error("cause register too wide");

  property p_stop;
    @(posedge CLK_I) disable iff (!RST_N_I)
      SLIM_STOP_O |-> $past(slact) == aclc_pkg::ACLC_SL_STOP;
  endproperty
  a_stop: assert property (p_stop) else $error("stop without stop action");
endmodule

// ---- test/aclc_pin_model.sv ----
// Purpose: Drives the trigger pins that feed the capture channels.
// Assumes: Pins change just after a rising clock edge and then hold.
// Notes:   Index 0 latch, 1 origin, 2 index, 3 to 6 general pins four to seven.
`timescale 1ns/1ps
module aclc_pin_model (
  input  wire logic       clk_i,
  output logic      [6:0] pins_o
);
  initial pins_o = 7'h00;

  // One pin is moved and then held for the given number of cycles.
  task drive(input int sel, input logic lvl, input int hold);
    @(posedge clk_i);
    pins_o[sel] <= lvl;
    repeat (hold) @(posedge clk_i);
  endtask

  task set_all(input logic lvl);
    @(posedge clk_i);
    pins_o <= {7{lvl}};
  endtask
endmodule

// ---- test/tb.sv ----
// Purpose: Self-checking bench for the counter, compare and capture block.
// Assumes: The register model is an associative array indexed by register index.
// Notes:   Captures use the shortest filter except where filter widths are tested.
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin mismatches++; \
  $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
  logic        clk;
  logic        rst_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic        c1i;
  logic        c1d;
  logic        c2i;
  logic        c2d;
  logic [31:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic [31:0] v;
  logic        pready;
  logic        pslverr;
  logic        stop;
  logic        decel;
  logic        irq;
  logic        err;
  logic [6:0]  pins;
  logic [31:0] mdl [int];
  logic [7:0]  all_idx [14];
  int          mismatches;
  int          comparisons;
  int          cyc;
  int          seed;
  int          cnt;

  always #2.5 clk = ~clk;

  aclc_top i_aclc_top (.CLK_I(clk), .RST_N_I(rst_n), .PADDR_I(paddr), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
    .CNT1_INC_I(c1i), .CNT1_DEC_I(c1d), .CNT2_INC_I(c2i), .CNT2_DEC_I(c2d), .LATCH_INPUT_PIN_I(pins[0]),
    .ORIGIN_INPUT_PIN_I(pins[1]), .ENCODER_INDEX_PIN_I(pins[2]), .GENERAL_PIN_I(pins[6:3]),
    .SLIM_STOP_O(stop), .SLIM_DECEL_O(decel), .IRQ_O(irq));

  aclc_pin_model pm (.clk_i(clk), .pins_o(pins));

  task wrap_up();
    if (mismatches == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      mismatches++;
      wrap_up();
    end
  end

  task step(input int n);
    repeat (n) @(posedge clk);
  endtask

  // The request holds until pready is seen high at a rising edge.
  task apb(input logic w, input logic [7:0] idx, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= {22'h000000, idx, 2'h0};
    pwrite <= w;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [7:0] idx, input logic [31:0] val);
    apb(1'b1, idx, val);
    if (idx == aclc_pkg::IDX_LATCH_CFG)
      mdl[idx] = val & aclc_pkg::CFG_MASK;
    else if (idx == aclc_pkg::IDX_IRQ_EN)
      mdl[idx] = val & aclc_pkg::IRQ_EN_MASK;
    else if (idx < aclc_pkg::IDX_CAP_ONE || idx > aclc_pkg::IDX_CAP_FOUR)
      mdl[idx] = val;
  endtask

  task rchk(input logic [7:0] idx);
    apb(1'b0, idx, 32'h0000_0000);
    `CHK(rd, mdl[idx])
  endtask

  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    {psel, penable, pwrite, c1i, c1d, c2i, c2d} = 7'h00;
    paddr = 32'h0000_0000;
    pwdata = 32'h0000_0000;
    {cyc, mismatches, comparisons, cnt} = 128'h0;
    seed = 32'hc26d;
    all_idx = '{aclc_pkg::IDX_LATCH_CFG, aclc_pkg::IDX_POS_ONE, aclc_pkg::IDX_POS_TWO, aclc_pkg::IDX_CMP_ONE,
      aclc_pkg::IDX_CMP_TWO, aclc_pkg::IDX_SLIM_A, aclc_pkg::IDX_SLIM_B, aclc_pkg::IDX_IRQ_EN,
      aclc_pkg::IDX_CAP_ONE, aclc_pkg::IDX_CAP_TWO, aclc_pkg::IDX_CAP_THREE, aclc_pkg::IDX_CAP_FOUR,
      aclc_pkg::IDX_ERR_CAUSE, aclc_pkg::IDX_EVT_CAUSE};
    step(6);
    rst_n <= 1'b1;
    for (int i = 0; i < 14; i++) begin
      mdl[all_idx[i]] = 32'h0000_0000;
      rchk(all_idx[i]);
    end
    for (int i = 0; i < 12; i++) begin
      wr(all_idx[i], $random(seed));
      rchk(all_idx[i]);
    end
    apb(1'b0, 8'h10, 32'h0000_0000);
    `CHK(err, 1'b1)
    // Counter one wraps from the largest positive to the most negative value.
    wr(aclc_pkg::IDX_POS_ONE, 32'h7FFF_FFFF);
    @(posedge clk);
    c1i <= 1'b1;
    @(posedge clk);
    c1i <= 1'b0;
    mdl[aclc_pkg::IDX_POS_ONE] = 32'h8000_0000;
    rchk(aclc_pkg::IDX_POS_ONE);
    wr(aclc_pkg::IDX_POS_TWO, 32'h0000_0000);
    repeat (40) begin
      @(posedge clk);
      v = $random(seed);
      c2i <= v[0];
      c2d <= v[1];
      cnt += int'(v[0]) - int'(v[1]);
    end
    @(posedge clk);
    {c2i, c2d} <= 2'h0;
    mdl[aclc_pkg::IDX_POS_TWO] = 32'(cnt);
    rchk(aclc_pkg::IDX_POS_TWO);
    // Channel three: latch pin, rising edge, counter one, first trigger only.
    wr(aclc_pkg::IDX_LATCH_CFG, 32'h0000_0009);
    step(aclc_pkg::FILT0_CYC);
    wr(aclc_pkg::IDX_IRQ_EN, 32'h0001_0000);
    v = $random(seed);
    wr(aclc_pkg::IDX_POS_ONE, v);
    wr(aclc_pkg::IDX_CTRL, 32'h0000_0001);
    pm.drive(0, 1'b1, 40);
    mdl[aclc_pkg::IDX_CAP_THREE] = v;
    rchk(aclc_pkg::IDX_CAP_THREE);
    `CHK(irq, 1'b1)
    apb(1'b0, aclc_pkg::IDX_EVT_CAUSE, 32'h0000_0000);
    `CHK(rd, 32'h0004_0000)
    wr(aclc_pkg::IDX_POS_ONE, v + 1);
    pm.drive(0, 1'b0, 40);
    pm.drive(0, 1'b1, 40);
    rchk(aclc_pkg::IDX_CAP_THREE);
    wr(aclc_pkg::IDX_CTRL, 32'h0000_0001);
    pm.drive(0, 1'b0, 40);
    pm.drive(0, 1'b1, 40);
    mdl[aclc_pkg::IDX_CAP_THREE] = v + 1;
    rchk(aclc_pkg::IDX_CAP_THREE);
    wr(aclc_pkg::IDX_EVT_CAUSE, 32'h0004_0000);
    step(2);
    `CHK(irq, 1'b0)
    // A pulse shorter than the 3.2 us filter never reaches the channel.
    wr(aclc_pkg::IDX_LATCH_CFG, 32'h0000_0069);
    step(aclc_pkg::FILT1_CYC);
    wr(aclc_pkg::IDX_CTRL, 32'h0000_0001);
    wr(aclc_pkg::IDX_POS_ONE, v + 2);
    pm.drive(0, 1'b0, 300);
    pm.drive(0, 1'b1, 700);
    rchk(aclc_pkg::IDX_CAP_THREE);
    for (int k = 2; k < 4; k++) begin
      wr(aclc_pkg::IDX_POS_ONE, v + k);
      pm.drive(0, 1'b0, 700);
      pm.drive(0, 1'b1, 700);
      mdl[aclc_pkg::IDX_CAP_THREE] = v + k;
      rchk(aclc_pkg::IDX_CAP_THREE);
    end
    wr(aclc_pkg::IDX_LATCH_CFG, 32'h0000_0068);
    step(aclc_pkg::FILT1_CYC);
    wr(aclc_pkg::IDX_CTRL, 32'h0000_0001);
    wr(aclc_pkg::IDX_POS_ONE, v + 4);
    pm.drive(0, 1'b0, 700);
    pm.drive(0, 1'b1, 700);
    rchk(aclc_pkg::IDX_CAP_THREE);
    wr(aclc_pkg::IDX_EVT_CAUSE, 32'h0004_0000);
    // Channel four: falling edge, counter two, every trigger, each source; its event stays masked.
    pm.set_all(1'b1);
    step(40);
    for (int s = 1; s < 8; s++) begin
      wr(aclc_pkg::IDX_LATCH_CFG, (32'(s) | 32'h0000_0030) << 8);
      step(aclc_pkg::FILT0_CYC);
      v = $random(seed);
      wr(aclc_pkg::IDX_POS_TWO, v);
      wr(aclc_pkg::IDX_CTRL, 32'h0000_0002);
      pm.drive(s - 1, 1'b0, 40);
      mdl[aclc_pkg::IDX_CAP_FOUR] = v;
      rchk(aclc_pkg::IDX_CAP_FOUR);
      wr(aclc_pkg::IDX_POS_TWO, ~v);
      pm.drive(s - 1, 1'b1, 40);
      rchk(aclc_pkg::IDX_CAP_FOUR);
    end
    `CHK(irq, 1'b0)
    apb(1'b0, aclc_pkg::IDX_EVT_CAUSE, 32'h0000_0000);
    `CHK(rd, 32'h0008_0000)
    wr(aclc_pkg::IDX_EVT_CAUSE, 32'h0008_0000);
    // The host latch command copies each counter into its own capture.
    wr(aclc_pkg::IDX_CTRL, 32'h0000_0004);
    step(2);
    mdl[aclc_pkg::IDX_CAP_ONE] = mdl[aclc_pkg::IDX_POS_ONE];
    mdl[aclc_pkg::IDX_CAP_TWO] = mdl[aclc_pkg::IDX_POS_TWO];
    rchk(aclc_pkg::IDX_CAP_ONE);
    rchk(aclc_pkg::IDX_CAP_TWO);
    // Software limit: stop at the positive limit, then decelerate.
    wr(aclc_pkg::IDX_SLIM_A, 32'h0000_0064);
    wr(aclc_pkg::IDX_SLIM_B, 32'hFFFF_FF9C);
    wr(aclc_pkg::IDX_POS_ONE, 32'h0000_0064);
    wr(aclc_pkg::IDX_POS_TWO, 32'h0000_0000);
    wr(aclc_pkg::IDX_CTRL, 32'h0000_0030);
    step(6);
    `CHK(stop, 1'b0)
    wr(aclc_pkg::IDX_POS_ONE, 32'h0000_0064);
    wr(aclc_pkg::IDX_POS_TWO, 32'h0000_0064);
    step(6);
    `CHK(stop, 1'b1)
    `CHK(decel, 1'b0)
    apb(1'b0, aclc_pkg::IDX_ERR_CAUSE, 32'h0000_0000);
    `CHK(rd, 32'h0000_0200)
    `CHK(irq, 1'b1)
    wr(aclc_pkg::IDX_CTRL, 32'h0000_0018);
    step(6);
    `CHK(decel, 1'b1)
    `CHK(stop, 1'b0)
    wrap_up();
  end
endmodule
